// [src/timer_pkg.sv]
// Shared constants and types of the standard timer compare unit
package timer_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int unsigned REG_ADDR_W = 3;
    localparam logic [2:0] ADDR_CONTROL_ONE = 3'h0;
    localparam logic [2:0] ADDR_COUNT_LOW = 3'h1;
    localparam logic [2:0] ADDR_COUNT_HIGH = 3'h2;
    localparam logic [2:0] ADDR_CMP_A_LOW = 3'h3;
    localparam logic [2:0] ADDR_CMP_A_HIGH = 3'h4;
    localparam logic [2:0] ADDR_CMP_P_VALUE = 3'h5;
    localparam logic [2:0] ADDR_RUN_STATUS = 3'h6;

    // Run/status register bit positions
    localparam int unsigned STAT_RUN_BIT = 0;
    localparam int unsigned STAT_AFLAG_BIT = 1;
    localparam int unsigned STAT_PFLAG_BIT = 2;

    // ------------------------------------------------------------
    // Field encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_COMPARE = 2'b00,
        MODE_CAPTURE = 2'b01,
        MODE_PWM = 2'b10,
        MODE_COUNTER = 2'b11
    } mode_type;

    // Compare match pin functions
    localparam logic [1:0] PIN_NO_CHANGE = 2'h0;
    localparam logic [1:0] PIN_GO_LOW = 2'h1;
    localparam logic [1:0] PIN_GO_HIGH = 2'h2;
    localparam logic [1:0] PIN_TOGGLE = 2'h3;
    // PWM mode pin functions
    localparam logic [1:0] PWM_FORCE_INACTIVE = 2'h0;
    localparam logic [1:0] PWM_FORCE_ACTIVE = 2'h1;
    localparam logic [1:0] PWM_WAVE = 2'h2;
    localparam logic [1:0] PWM_SINGLE_PULSE = 2'h3;

    // Control register one, bit 7 down to bit 0
    typedef struct packed {
        mode_type modeSel;
        logic [1:0] pinFunc;
        logic outputLevelCtl;
        logic outputInvert;
        logic periodDutySwap;
        logic clearSourceSel;
    } control_type;

    // Comparator results
    typedef struct packed {
        logic aMatch;
        logic pMatch;
        logic dutyActive;
    } match_type;

    // Whole state of the top module
    typedef struct packed {
        control_type ctl;
        logic [15:0] count;
        logic [15:0] compareAValue;
        logic [7:0] compareP;
        logic runEnable;
        logic runPrev;
        logic matchAFlag;
        logic matchPFlag;
        logic pinLevel;
        logic timerOutputPin;
        logic timerPinEnable;
        logic [7:0] regRdData;
    } timer_state_type;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam timer_state_type STATE_RESET = '0;

endpackage : timer_pkg

// [src/match_detect.sv]
// Comparator A, comparator P and PWM duty detection
module match_detect
    import timer_pkg::*;
(
    // Counter and compare values
    input wire logic [15:0] count,
    input wire logic [15:0] compareAValue,
    input wire logic [7:0] compareP,
    // Control
    input wire logic periodDutySwap,
    input wire logic running,
    // Results
    output match_type match
);

    // Value the counter takes on its next tick
    function automatic logic [15:0] plusOne(input logic [15:0] v);
        return v + 16'h0001;
    endfunction : plusOne

    // Match fires on the tick that would reach the compare value
    always_comb begin
        match.aMatch = running && (plusOne(count) == compareAValue);
        // P match needs the next count to equal P times 256, low byte zero; zero matches on overflow
        match.pMatch = running && (plusOne(count) == {compareP, 8'h00});
        if (periodDutySwap) begin
            match.dutyActive = (compareP == 8'h00) || (count < {compareP, 8'h00});
        end else begin
            match.dutyActive = count < compareAValue;
        end
    end

endmodule : match_detect

// [src/pin_level_calc.sv]
// Next level and drive enable of the timer output pin
module pin_level_calc
    import timer_pkg::*;
(
    // Configuration and events
    input control_type ctl,
    input match_type match,
    input wire logic runRise,
    input wire logic running,
    input wire logic pinLevel,
    // Results
    output logic nextLevel,
    output logic pinEnable
);

    always_comb begin
        nextLevel = pinLevel;
        pinEnable = 1'b0;
        case (ctl.modeSel)
            MODE_COMPARE: begin
                pinEnable = 1'b1;
                if (runRise) begin
                    nextLevel = ctl.outputLevelCtl;
                end else if (match.aMatch) begin
                    case (ctl.pinFunc)
                        PIN_GO_LOW: nextLevel = 1'b0;
                        PIN_GO_HIGH: nextLevel = 1'b1;
                        PIN_TOGGLE: nextLevel = ~pinLevel;
                        default: nextLevel = pinLevel;
                    endcase
                end
            end
            MODE_PWM: begin
                pinEnable = 1'b1;
                // Control bit picks the active level
                case (ctl.pinFunc)
                    PWM_FORCE_ACTIVE: nextLevel = ctl.outputLevelCtl;
                    PWM_WAVE: nextLevel = match.dutyActive ~^ ctl.outputLevelCtl;
                    PWM_SINGLE_PULSE: nextLevel = running ~^ ctl.outputLevelCtl;
                    default: nextLevel = ~ctl.outputLevelCtl;
                endcase
            end
            default: begin
                nextLevel = pinLevel;
                pinEnable = 1'b0;
            end
        endcase
    end

endmodule : pin_level_calc

// [src/standard_timer_compare_unit.sv]
// Standard timer compare unit: 16-bit counter, comparators A and P, register port
//
// Overview of operation
// - Compare mode: control bit gives pin level before first A match; ignored in counter mode.
// - PWM or single pulse: control bit picks active level, 0 low, 1 high.
// - Polarity bit set inverts pin; no effect in counter mode (this design still inverts timerOutputPin there, with drive off).
// - Swap bit 0: P period, A duty; 1: P duty, A period.
// - Clear select 1 clears on A match; 0 clears on P match or overflow.
// - Overflow clearing only with P value zero, wrapping at maximum.
// - Clear select ignored in PWM, single pulse and capture modes.
// - Counter readable as low byte bits 7..0 and high byte 15..8.
// - Comparator A held in writable, readable low and high byte registers.
// - P compares counter top byte; period value times 256, zero gives 65536.
// - Mode field 00 selects compare match output mode.
// - Compare mode, clear select 0: both A and P flags raised.
// - Clear select 1: only A flag raised, never P flag.
// - Compare mode: pin changes only on A match, never on P match.
// - Pin function on A match: high, low, toggle, or zero for no change.
// - Compare mode: run enable rising edge sets pin to control bit initial level.
// - Counter mode clears and flags like compare mode, pin not driven.
//
// Strobed register access and the placing of the registers are this design's own decisions.
module standard_timer_compare_unit
    import timer_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register port
    input wire logic [REG_ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    // Timer output pin
    output logic timerOutputPin,
    output logic timerPinEnable
);

    // ------------------------------------------------------------
    // State and comparators
    // ------------------------------------------------------------
    timer_state_type st;
    timer_state_type next_st;
    match_type match;
    logic runRise;
    logic singlePulse;
    logic counterClear;
    logic pFlagAllowed;
    logic pinNext;
    logic pinDrive;
    logic countHighWrite;
    logic controlWrite;

    // Rising edge of the run enable bit
    assign runRise = st.runEnable & ~st.runPrev;
    assign singlePulse = (st.ctl.modeSel == MODE_PWM) && (st.ctl.pinFunc == PWM_SINGLE_PULSE);
    assign countHighWrite = regWr && (regAddr == ADDR_COUNT_HIGH);
    assign controlWrite = regWr && (regAddr == ADDR_CONTROL_ONE);

    // Comparator A, comparator P and duty test
    match_detect u_match (
        .count(st.count),
        .compareAValue(st.compareAValue),
        .compareP(st.compareP),
        .periodDutySwap(st.ctl.periodDutySwap),
        .running(st.runEnable),
        .match(match)
    );

    // Pin level for the next cycle
    pin_level_calc u_pin (
        .ctl(st.ctl),
        .match(match),
        .runRise(runRise),
        .running(st.runEnable),
        .pinLevel(st.pinLevel),
        .nextLevel(pinNext),
        .pinEnable(pinDrive)
    );

    // ------------------------------------------------------------
    // Clear source and flag gating by mode
    // ------------------------------------------------------------
    always_comb begin
        counterClear = 1'b0;
        pFlagAllowed = 1'b1;
        case (st.ctl.modeSel)
            MODE_COMPARE, MODE_COUNTER: begin
                // Clear select chooses A match or P match / overflow
                counterClear = st.ctl.clearSourceSel ? match.aMatch : match.pMatch;
                pFlagAllowed = ~st.ctl.clearSourceSel;
            end
            MODE_PWM: begin
                if (singlePulse) begin
                    // Counter restarts only on a run rising edge
                    counterClear = runRise;
                    pFlagAllowed = 1'b0;
                end else begin
                    // Period comes from P or A as the swap bit says
                    counterClear = st.ctl.periodDutySwap ? match.aMatch : match.pMatch;
                end
            end
            MODE_CAPTURE: begin
                counterClear = match.pMatch;
            end
            default: begin
                counterClear = 1'b0;
                pFlagAllowed = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.regRdData = 8'h00;
        next_st.runPrev = st.runEnable;

        // Counter advances only while running
        if (st.runEnable) begin
            next_st.count = counterClear ? 16'h0000 : st.count + 16'h0001;
        end

        // Register writes
        if (regWr) begin
            case (regAddr)
                ADDR_CONTROL_ONE: next_st.ctl = control_type'(regWrData);
                ADDR_COUNT_HIGH: next_st.count[15:8] = regWrData;
                ADDR_CMP_A_LOW: next_st.compareAValue[7:0] = regWrData;
                ADDR_CMP_A_HIGH: next_st.compareAValue[15:8] = regWrData;
                ADDR_CMP_P_VALUE: next_st.compareP = regWrData;
                ADDR_RUN_STATUS: begin
                    next_st.runEnable = regWrData[STAT_RUN_BIT];
                    // Writing one clears a flag
                    if (regWrData[STAT_AFLAG_BIT]) begin
                        next_st.matchAFlag = 1'b0;
                    end
                    if (regWrData[STAT_PFLAG_BIT]) begin
                        next_st.matchPFlag = 1'b0;
                    end
                end
                default: next_st.runEnable = st.runEnable;
            endcase
        end

        // Flag sets win over a clear in the same cycle
        if (match.aMatch && (st.ctl.modeSel != MODE_CAPTURE)) begin
            next_st.matchAFlag = 1'b1;
        end
        if (match.pMatch && pFlagAllowed) begin
            next_st.matchPFlag = 1'b1;
        end

        // Single pulse ends on comparator A match
        if (singlePulse && match.aMatch) begin
            next_st.runEnable = 1'b0;
        end

        // Pin level, polarity and drive enable
        next_st.pinLevel = pinNext;
        next_st.timerOutputPin = pinNext ^ st.ctl.outputInvert;
        next_st.timerPinEnable = pinDrive;

        // Read data, one cycle after the strobe
        if (regRd) begin
            case (regAddr)
                ADDR_CONTROL_ONE: next_st.regRdData = st.ctl;
                ADDR_COUNT_LOW: next_st.regRdData = st.count[7:0];
                ADDR_COUNT_HIGH: next_st.regRdData = st.count[15:8];
                ADDR_CMP_A_LOW: next_st.regRdData = st.compareAValue[7:0];
                ADDR_CMP_A_HIGH: next_st.regRdData = st.compareAValue[15:8];
                ADDR_CMP_P_VALUE: next_st.regRdData = st.compareP;
                ADDR_RUN_STATUS: begin
                    next_st.regRdData[STAT_RUN_BIT] = st.runEnable;
                    next_st.regRdData[STAT_AFLAG_BIT] = st.matchAFlag;
                    next_st.regRdData[STAT_PFLAG_BIT] = st.matchPFlag;
                end
                default: next_st.regRdData = 8'h00;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (srst) begin
            st <= STATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flip-flops
    assign regRdData = st.regRdData;
    assign timerOutputPin = st.timerOutputPin;
    assign timerPinEnable = st.timerPinEnable;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------

    // Run rising edge loads the initial level, polarity applied
    initial_level_a: assert property (
        @(posedge clk) disable iff (srst)
        (runRise && st.ctl.modeSel == MODE_COMPARE)
        |=> timerOutputPin == ($past(st.ctl.outputLevelCtl) ^ $past(st.ctl.outputInvert))
    ) else $error("pin not at initial level after run rise");

    // Counter holds while stopped
    counter_hold_a: assert property (
        @(posedge clk) disable iff (srst)
        (!st.runEnable && !countHighWrite) |=> $stable(st.count)
    ) else $error("counter moved while stopped");

    // Counter steps by one while running
    counter_step_a: assert property (
        @(posedge clk) disable iff (srst)
        (st.runEnable && !counterClear && !countHighWrite)
        |=> st.count == $past(st.count) + 16'h0001
    ) else $error("counter did not step by one");

    // Clear select one clears on A match
    clear_on_a_a: assert property (
        @(posedge clk) disable iff (srst)
        (st.ctl.modeSel == MODE_COMPARE && st.ctl.clearSourceSel && match.aMatch
            && !countHighWrite)
        |=> st.count == 16'h0000
    ) else $error("counter not cleared on comparator A match");

    // P match lands on value times 256, zero on wrap
    p_period_a: assert property (
        @(posedge clk) disable iff (srst)
        match.pMatch |-> (st.count[7:0] == 8'hFF) && (st.count[15:8] == st.compareP - 8'h01)
    ) else $error("comparator P matched at wrong count");

    // Clear select zero clears on P match or overflow
    clear_on_p_a: assert property (
        @(posedge clk) disable iff (srst)
        (st.ctl.modeSel == MODE_COUNTER && !st.ctl.clearSourceSel && match.pMatch
            && !countHighWrite)
        |=> st.count == 16'h0000
    ) else $error("counter not cleared on comparator P match");

    // No P flag with clear select one
    no_p_flag_a: assert property (
        @(posedge clk) disable iff (srst)
        (st.ctl.modeSel == MODE_COMPARE && st.ctl.clearSourceSel && !st.matchPFlag)
        |=> !st.matchPFlag
    ) else $error("P flag raised with clear select set");

    // A match raises the A flag
    a_flag_set_a: assert property (
        @(posedge clk) disable iff (srst)
        (match.aMatch && st.ctl.modeSel == MODE_COMPARE) |=> st.matchAFlag
    ) else $error("A flag not raised on match");

    // P match raises the P flag with clear select zero
    p_flag_set_a: assert property (
        @(posedge clk) disable iff (srst)
        (match.pMatch && st.ctl.modeSel == MODE_COMPARE && !st.ctl.clearSourceSel)
        |=> st.matchPFlag
    ) else $error("P flag not raised on match");

    // Counter mode flags A matches like compare mode
    counter_flag_a: assert property (
        @(posedge clk) disable iff (srst)
        (match.aMatch && st.ctl.modeSel == MODE_COUNTER) |=> st.matchAFlag
    ) else $error("A flag not raised in counter mode");

    // P flag stays set until a write clears it
    p_flag_sticky_a: assert property (
        @(posedge clk) disable iff (srst)
        (st.matchPFlag && !(regWr && regAddr == ADDR_RUN_STATUS && regWrData[STAT_PFLAG_BIT]))
        |=> st.matchPFlag
    ) else $error("P flag dropped without a clear");

    // A flag stays set until a write clears it
    flag_sticky_a: assert property (
        @(posedge clk) disable iff (srst)
        (st.matchAFlag && !(regWr && regAddr == ADDR_RUN_STATUS && regWrData[STAT_AFLAG_BIT]))
        |=> st.matchAFlag
    ) else $error("A flag dropped without a clear");

    // Pin holds in compare mode without an A match
    pin_quiet_a: assert property (
        @(posedge clk) disable iff (srst)
        (!controlWrite) ##1 (st.ctl.modeSel == MODE_COMPARE && !match.aMatch && !runRise)
        |=> $stable(timerOutputPin)
    ) else $error("pin changed without comparator A match");

    // Toggle function flips the pin on A match
    pin_toggle_a: assert property (
        @(posedge clk) disable iff (srst)
        (st.ctl.modeSel == MODE_COMPARE && st.ctl.pinFunc == PIN_TOGGLE && match.aMatch
            && !runRise)
        |=> st.pinLevel != $past(st.pinLevel)
    ) else $error("pin did not toggle on match");

    // Go-high function drives the pin high on A match
    pin_high_a: assert property (
        @(posedge clk) disable iff (srst)
        (st.ctl.modeSel == MODE_COMPARE && st.ctl.pinFunc == PIN_GO_HIGH && match.aMatch
            && !runRise)
        |=> st.pinLevel
    ) else $error("pin not high after match");

    // Go-low function drives the pin low on A match
    pin_low_a: assert property (
        @(posedge clk) disable iff (srst)
        (st.ctl.modeSel == MODE_COMPARE && st.ctl.pinFunc == PIN_GO_LOW && match.aMatch
            && !runRise)
        |=> !st.pinLevel
    ) else $error("pin not low after match");

    // Zero function leaves the pin alone on A match
    pin_none_a: assert property (
        @(posedge clk) disable iff (srst)
        (st.ctl.modeSel == MODE_COMPARE && st.ctl.pinFunc == PIN_NO_CHANGE && match.aMatch
            && !runRise)
        |=> $stable(st.pinLevel)
    ) else $error("pin changed with no-change function");

    // Pin shows the level through the polarity bit
    pin_invert_a: assert property (
        @(posedge clk) disable iff (srst)
        (!controlWrite) |=> timerOutputPin == (st.pinLevel ^ st.ctl.outputInvert)
    ) else $error("pin polarity wrong");

    // Count high byte write replaces bits 15 to 8
    count_write_a: assert property (
        @(posedge clk) disable iff (srst)
        (regWr && regAddr == ADDR_COUNT_HIGH) |=> st.count[15:8] == $past(regWrData)
    ) else $error("count high byte write lost");

    // Counter mode never drives the pin
    pin_released_a: assert property (
        @(posedge clk) disable iff (srst)
        (st.ctl.modeSel == MODE_COUNTER) |=> !timerPinEnable
    ) else $error("pin driven in counter mode");

    // Counter low byte reads back one cycle later
    count_read_a: assert property (
        @(posedge clk) disable iff (srst)
        (regRd && regAddr == ADDR_COUNT_LOW) |=> regRdData == $past(st.count[7:0])
    ) else $error("counter low byte read wrong");

    // Comparator A high byte reads back what was written
    cmp_a_read_a: assert property (
        @(posedge clk) disable iff (srst)
        (regWr && regAddr == ADDR_CMP_A_HIGH) ##1 (!regWr)
        ##1 (regRd && regAddr == ADDR_CMP_A_HIGH)
        |=> regRdData == $past(regWrData, 3)
    ) else $error("comparator A high byte read wrong");

endmodule : standard_timer_compare_unit

// [verification/tb_top.sv]
// Self-checking testbench of the standard timer compare unit
module tb_top
    import timer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk;
    logic srst;
    logic [2:0] regAddr;
    logic [7:0] regWrData;
    logic regWr;
    logic regRd;
    logic [7:0] regRdData;
    logic timerOutputPin;
    logic timerPinEnable;
    int fails;
    int comparisons;
    logic [7:0] rdVal;

    // Register rows: address, write data, value read back
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] data;
        logic [7:0] readBack;
    } row_type;
    row_type rows [8];

    standard_timer_compare_unit dut (
        .clk(clk),
        .srst(srst),
        .regAddr(regAddr),
        .regWrData(regWrData),
        .regWr(regWr),
        .regRd(regRd),
        .regRdData(regRdData),
        .timerOutputPin(timerOutputPin),
        .timerPinEnable(timerPinEnable)
    );

    // 50 ns clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic test_done;
        if (fails == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done

    // One-cycle write strobe
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr

    // One-cycle read strobe, data taken in the following cycle only
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        d = regRdData;
    endtask : rd

    // Stop, clear both flags, configure, start
    task automatic go(input logic [7:0] ctl);
        wr(ADDR_RUN_STATUS, 8'h06);
        wr(ADDR_CONTROL_ONE, ctl);
        wr(ADDR_RUN_STATUS, 8'h01);
    endtask : go

    // Wait whole cycles, then settle past the edge
    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cycles

    task automatic do_reset(input int n);
        @(posedge clk);
        srst <= 1'b1;
        repeat (n) @(posedge clk);
        srst <= 1'b0;
    endtask : do_reset

    // Guard against a hang
    initial begin
        repeat (100000) @(posedge clk);
        fails++;
        test_done();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        fails = 0;
        comparisons = 0;
        srst = 1'b1;
        regAddr = 3'h0;
        regWrData = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        rows[0] = '{ADDR_COUNT_LOW, 8'h5A, 8'h00};
        rows[1] = '{ADDR_COUNT_HIGH, 8'h34, 8'h34};
        rows[2] = '{ADDR_CMP_A_LOW, 8'hA5, 8'hA5};
        rows[3] = '{ADDR_CMP_A_HIGH, 8'h5A, 8'h5A};
        rows[4] = '{ADDR_CMP_P_VALUE, 8'hC3, 8'hC3};
        rows[5] = '{ADDR_CONTROL_ONE, 8'h3C, 8'h3C};
        rows[6] = '{3'h7, 8'hFF, 8'h00};
        rows[7] = '{ADDR_RUN_STATUS, 8'h06, 8'h00};
        repeat (10) @(posedge clk);
        srst <= 1'b0;

        // Reset value, write, read back of every address
        foreach (rows[i]) begin
            rd(rows[i].addr, rdVal);
            check("reset value", {8'h00, rdVal}, 16'h0000);
            wr(rows[i].addr, rows[i].data);
            rd(rows[i].addr, rdVal);
            check("read back", {8'h00, rdVal}, {8'h00, rows[i].readBack});
        end

        // Second reset in mid-run returns registers and pin to zero
        wr(ADDR_RUN_STATUS, 8'h01);
        cycles(5);
        do_reset(2);
        rd(ADDR_CONTROL_ONE, rdVal);
        check("control after reset", {8'h00, rdVal}, 16'h0000);
        rd(ADDR_COUNT_HIGH, rdVal);
        check("count high after reset", {8'h00, rdVal}, 16'h0000);
        check("pin after reset", {15'h0, timerOutputPin}, 16'h0000);

        // Every pin function on an A match, clear on A
        wr(ADDR_CMP_A_LOW, 8'h20);
        wr(ADDR_CMP_A_HIGH, 8'h00);
        wr(ADDR_CMP_P_VALUE, 8'h00);
        for (int f = 0; f < 4; f++) begin
            logic init;
            logic after;
            init = (f == 2) ? 1'b0 : 1'b1;
            // Go-low, or one toggle from high, ends low
            after = (f == 1 || f == 3) ? 1'b0 : 1'b1;
            go({MODE_COMPARE, f[1:0], init, 3'b001});
            cycles(2);
            check("initial level", {15'h0, timerOutputPin}, {15'h0, init});
            check("pin enable", {15'h0, timerPinEnable}, 16'h0001);
            cycles(38);
            check("level after A", {15'h0, timerOutputPin}, {15'h0, after});
            rd(ADDR_COUNT_LOW, rdVal);
            check("count cleared by A", {15'h0, rdVal < 8'h20}, 16'h0001);
            rd(ADDR_RUN_STATUS, rdVal);
            check("only A flag", {8'h00, rdVal}, 16'h0003);
        end

        // Clear on P, pin ignores P, both flags, write-one clear
        wr(ADDR_CMP_A_LOW, 8'h80);
        wr(ADDR_CMP_P_VALUE, 8'h01);
        go({MODE_COMPARE, PIN_TOGGLE, 4'b0000});
        cycles(300);
        check("pin after P match", {15'h0, timerOutputPin}, 16'h0001);
        rd(ADDR_RUN_STATUS, rdVal);
        check("both flags", {8'h00, rdVal}, 16'h0007);
        rd(ADDR_RUN_STATUS, rdVal);
        check("flags held", {8'h00, rdVal}, 16'h0007);
        rd(ADDR_COUNT_HIGH, rdVal);
        check("count cleared by P", {8'h00, rdVal}, 16'h0000);
        wr(ADDR_RUN_STATUS, 8'h07);
        rd(ADDR_RUN_STATUS, rdVal);
        check("flags cleared", {8'h00, rdVal}, 16'h0001);

        // Inverted initial level
        go({MODE_COMPARE, PIN_TOGGLE, 4'b0100});
        cycles(2);
        check("inverted level", {15'h0, timerOutputPin}, 16'h0001);

        // Stopped counter holds, high byte write
        wr(ADDR_RUN_STATUS, 8'h06);
        wr(ADDR_COUNT_HIGH, 8'hFF);
        rd(ADDR_COUNT_LOW, rdVal);
        begin
            logic [7:0] held;
            held = rdVal;
            cycles(4);
            rd(ADDR_COUNT_LOW, rdVal);
            check("count held", {8'h00, rdVal}, {8'h00, held});
        end
        rd(ADDR_COUNT_HIGH, rdVal);
        check("count high write", {8'h00, rdVal}, 16'h00FF);

        // Timer/counter mode, P zero: overflow wrap, P flag, no pin drive
        wr(ADDR_CMP_P_VALUE, 8'h00);
        wr(ADDR_RUN_STATUS, 8'h06);
        wr(ADDR_CONTROL_ONE, {MODE_COUNTER, 6'b000000});
        wr(ADDR_RUN_STATUS, 8'h01);
        cycles(300);
        check("counter mode enable", {15'h0, timerPinEnable}, 16'h0000);
        rd(ADDR_RUN_STATUS, rdVal);
        check("overflow P flag", {15'h0, rdVal[STAT_PFLAG_BIT]}, 16'h0001);
        rd(ADDR_COUNT_HIGH, rdVal);
        check("count wrapped", {15'h0, rdVal < 8'h02}, 16'h0001);

        // PWM forced levels follow the active level bit
        for (int g = 0; g < 4; g++) begin
            go({MODE_PWM, 1'b0, g[1], g[0], 3'b000});
            cycles(3);
            check("pwm forced level", {15'h0, timerOutputPin}, {15'h0, g[1] ~^ g[0]});
        end

        test_done();
    end

endmodule : tb_top
